// [ssw_pkg.sv]
// Purpose: shared constants, states and output bundle of the supply supervisor with watchdog
// Assumes: one 200 MHz clock; every long interval counts a 1 us tick from one divider
// Notes: tick counts are defaults for the top parameters so a simulation may shorten them
`default_nettype none
package ssw_pkg;
	// ***************************************
	// timebase
	// ***************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS = 1000;
	localparam int DIV_W = 8;
	localparam int CNT_W = 20;
	localparam int FLT_W = 11;
	localparam logic [DIV_W-1:0] TICK_CYCLES_DEF = DIV_W'(TICK_NS / CLK_PERIOD_NS);

	// ***************************************
	// intervals, each a least time
	// ***************************************
	localparam int RST_HOLD_MS = 130;
	localparam int NMI_PULSE_US = 200;
	localparam int WD_TIMEOUT_S = 1;
	localparam int WD_EXPIRED_MS = 130;
	localparam logic [CNT_W-1:0] RST_HOLD_TICKS_DEF = CNT_W'(RST_HOLD_MS * 1000000 / TICK_NS);
	localparam logic [CNT_W-1:0] NMI_PULSE_TICKS_DEF = CNT_W'(NMI_PULSE_US * 1000 / TICK_NS);
	localparam logic [CNT_W-1:0] WD_TIMEOUT_TICKS_DEF = CNT_W'(WD_TIMEOUT_S * 1000000000 / TICK_NS);
	localparam logic [CNT_W-1:0] WD_EXPIRED_TICKS_DEF = CNT_W'(WD_EXPIRED_MS * 1000000 / TICK_NS);

	// ***************************************
	// input filters, in clock cycles
	// ***************************************
	localparam int SUPPLY_GLITCH_NS = 2000;
	localparam int SENSE_FILTER_NS = 5000;
	localparam int PB_DEBOUNCE_NS = 150;
	localparam logic [FLT_W-1:0] SUPPLY_GLITCH_CYC = FLT_W'((SUPPLY_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [FLT_W-1:0] SENSE_FILTER_CYC = FLT_W'((SENSE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [FLT_W-1:0] PB_DEBOUNCE_CYC = FLT_W'((PB_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ***************************************
	// states and outputs
	// ***************************************
	typedef enum logic [1:0] {RST_HOLD = 2'h0, RST_STRETCH = 2'h1, RST_RUN = 2'h3} ssw_rst_state_t;
	typedef enum logic [1:0] {NMI_IDLE = 2'h0, NMI_PULSE = 2'h1, NMI_WAIT = 2'h3} ssw_nmi_state_t;
	typedef enum logic [1:0] {WD_OFF = 2'h0, WD_RUN = 2'h1, WD_EXPIRED = 2'h3} ssw_wd_state_t;
	typedef struct packed {
		logic reset_n;
		logic reset;
		logic nmi_n;
		logic wds_n;
	} ssw_outs_t;
	localparam ssw_outs_t OUTS_RST = '{reset_n: 1'h0, reset: 1'h1, nmi_n: 1'h1, wds_n: 1'h1};
	localparam logic STROBE_RST = 1'h1;
endpackage
`default_nettype wire

// [ssw_top.sv]
// Purpose: supply supervisor: power and pushbutton reset, early-warning interrupt, watchdog
// Assumes: comparator results arrive as synchronous digital levels; inputs synchronous to clk
// Notes: every long interval is counted in 1 us ticks from one free-running divider; input filters count clock cycles
// Behaviour
// - reset output active whenever supply-low comparator has reported supply low for about 2 us
// - after supply recovers, reset stays active at least 130 ms
// - pushbutton input is active low and debounced before use
// - reset active while pushbutton low, then at least 130 ms after release
// - sense at or below trip point pulses interrupt low at least 200 us
// - interrupt only after sense stays low about 5 us
// - interrupt suppressed while supply is below its trip point
// - watchdog timing starts when reset ends, halted during reset
// - each strobe falling edge before expiry restarts the full timeout
// - on expiry watchdog status goes low at least 130 ms
// - active-high reset output mirrors active-low reset with opposite polarity
// - supply-low pulses shorter than about 2 us cause no reset
`timescale 1ns/1ps
`default_nettype none
module ssw_top
	import ssw_pkg::*;
#(
	parameter logic [DIV_W-1:0] TICK_CYCLES = TICK_CYCLES_DEF,
	parameter logic [CNT_W-1:0] RST_HOLD_TICKS = RST_HOLD_TICKS_DEF,
	parameter logic [CNT_W-1:0] NMI_PULSE_TICKS = NMI_PULSE_TICKS_DEF,
	parameter logic [CNT_W-1:0] WD_TIMEOUT_TICKS = WD_TIMEOUT_TICKS_DEF,
	parameter logic [CNT_W-1:0] WD_EXPIRED_TICKS = WD_EXPIRED_TICKS_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic supply_low,
	input wire logic sense_low,
	input wire logic pushbutton_reset_n,
	input wire logic watchdog_strobe_n,
	output logic reset_n,
	output logic reset,
	output logic nmi_n,
	output logic watchdog_expired_n
);
	// ***************************************
	// timebase and input filters
	// ***************************************
	logic [DIV_W-1:0] div_cnt_ff, nxt_div_cnt;
	logic tick_ff, nxt_tick;
	logic [FLT_W-1:0] sup_cnt_ff, nxt_sup_cnt, sense_cnt_ff, nxt_sense_cnt, pb_cnt_ff, nxt_pb_cnt;
	logic supply_fail_ff, nxt_supply_fail, sense_fail_ff, nxt_sense_fail, pb_low_ff, nxt_pb_low;

	always_comb begin
		nxt_div_cnt = div_cnt_ff + 1'b1;
		nxt_tick = 1'b0;
		if (div_cnt_ff == TICK_CYCLES - 1'b1) begin
			nxt_div_cnt = '0;
			nxt_tick = 1'b1;
		end
		// short dips never reach the count, so they cannot start a reset
		nxt_sup_cnt = '0;
		nxt_supply_fail = 1'b0;
		if (supply_low) begin
			nxt_supply_fail = supply_fail_ff;
			nxt_sup_cnt = sup_cnt_ff + 1'b1;
			if (sup_cnt_ff == SUPPLY_GLITCH_CYC - 1'b1) begin
				nxt_sup_cnt = sup_cnt_ff;
				nxt_supply_fail = 1'b1;
			end
		end
		nxt_sense_cnt = '0;
		nxt_sense_fail = 1'b0;
		if (sense_low) begin
			nxt_sense_fail = sense_fail_ff;
			nxt_sense_cnt = sense_cnt_ff + 1'b1;
			if (sense_cnt_ff == SENSE_FILTER_CYC - 1'b1) begin
				nxt_sense_cnt = sense_cnt_ff;
				nxt_sense_fail = 1'b1;
			end
		end
		// debounce both ways: the level must differ for the whole window to flip
		nxt_pb_cnt = '0;
		nxt_pb_low = pb_low_ff;
		if (!pushbutton_reset_n != pb_low_ff) begin
			nxt_pb_cnt = pb_cnt_ff + 1'b1;
			if (pb_cnt_ff == PB_DEBOUNCE_CYC - 1'b1) begin
				nxt_pb_cnt = '0;
				nxt_pb_low = !pushbutton_reset_n;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_ff <= '0;
			tick_ff <= 1'b0;
			sup_cnt_ff <= '0;
			supply_fail_ff <= 1'b0;
			sense_cnt_ff <= '0;
			sense_fail_ff <= 1'b0;
			pb_cnt_ff <= '0;
			pb_low_ff <= 1'b0;
		end else begin
			div_cnt_ff <= nxt_div_cnt;
			tick_ff <= nxt_tick;
			sup_cnt_ff <= nxt_sup_cnt;
			supply_fail_ff <= nxt_supply_fail;
			sense_cnt_ff <= nxt_sense_cnt;
			sense_fail_ff <= nxt_sense_fail;
			pb_cnt_ff <= nxt_pb_cnt;
			pb_low_ff <= nxt_pb_low;
		end
	end

	// ***************************************
	// sequencers and outputs
	// ***************************************
	// an interval that starts at an arbitrary divider phase ends on its count+1th tick,
	// trading up to one tick of extra length for a guaranteed least time
	ssw_rst_state_t rst_state_ff, nxt_rst_state;
	ssw_nmi_state_t nmi_state_ff, nxt_nmi_state;
	ssw_wd_state_t wd_state_ff, nxt_wd_state;
	logic [CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt, nmi_cnt_ff, nxt_nmi_cnt, wd_cnt_ff, nxt_wd_cnt;
	logic strobe_prev_ff, strobe_fall;
	ssw_outs_t outs_ff, nxt_outs;

	always_comb begin
		strobe_fall = strobe_prev_ff && !watchdog_strobe_n;
		nxt_rst_state = rst_state_ff;
		nxt_rst_cnt = rst_cnt_ff;
		unique case (rst_state_ff)
			RST_HOLD: begin
				nxt_rst_cnt = '0;
				if (!(supply_fail_ff || pb_low_ff)) nxt_rst_state = RST_STRETCH;
			end
			RST_STRETCH: begin
				if (supply_fail_ff || pb_low_ff) begin
					nxt_rst_state = RST_HOLD;
					nxt_rst_cnt = '0;
				end else if (tick_ff) begin
					if (rst_cnt_ff == RST_HOLD_TICKS) nxt_rst_state = RST_RUN;
					else nxt_rst_cnt = rst_cnt_ff + 1'b1;
				end
			end
			RST_RUN: begin
				if (supply_fail_ff || pb_low_ff) nxt_rst_state = RST_HOLD;
			end
			default: nxt_rst_state = RST_HOLD;
		endcase
		nxt_nmi_state = nmi_state_ff;
		nxt_nmi_cnt = nmi_cnt_ff;
		unique case (nmi_state_ff)
			NMI_IDLE: begin
				nxt_nmi_cnt = '0;
				if (sense_fail_ff && !supply_low) nxt_nmi_state = NMI_PULSE;
			end
			NMI_PULSE: begin
				if (tick_ff) begin
					if (nmi_cnt_ff == NMI_PULSE_TICKS) nxt_nmi_state = NMI_WAIT;
					else nxt_nmi_cnt = nmi_cnt_ff + 1'b1;
				end
			end
			NMI_WAIT: begin
				// one pulse per excursion; rearm only once the sense input recovers
				if (!sense_fail_ff) nxt_nmi_state = NMI_IDLE;
			end
			default: nxt_nmi_state = NMI_IDLE;
		endcase
		nxt_wd_state = wd_state_ff;
		nxt_wd_cnt = wd_cnt_ff;
		unique case (wd_state_ff)
			WD_OFF: begin
				nxt_wd_cnt = '0;
				if (rst_state_ff == RST_RUN) nxt_wd_state = WD_RUN;
			end
			WD_RUN: begin
				if (rst_state_ff != RST_RUN) begin
					nxt_wd_state = WD_OFF;
					nxt_wd_cnt = '0;
				end else if (strobe_fall) begin
					nxt_wd_cnt = '0;
				end else if (tick_ff) begin
					if (wd_cnt_ff == WD_TIMEOUT_TICKS) begin
						nxt_wd_state = WD_EXPIRED;
						nxt_wd_cnt = '0;
					end else begin
						nxt_wd_cnt = wd_cnt_ff + 1'b1;
					end
				end
			end
			WD_EXPIRED: begin
				// the status pulse always runs its full length, even if a reset begins
				if (tick_ff) begin
					if (wd_cnt_ff == WD_EXPIRED_TICKS) begin
						nxt_wd_state = (rst_state_ff == RST_RUN) ? WD_RUN : WD_OFF;
						nxt_wd_cnt = '0;
					end else begin
						nxt_wd_cnt = wd_cnt_ff + 1'b1;
					end
				end
			end
			default: nxt_wd_state = WD_OFF;
		endcase
		nxt_outs.reset_n = (nxt_rst_state == RST_RUN);
		nxt_outs.reset = (nxt_rst_state != RST_RUN);
		nxt_outs.nmi_n = (nxt_nmi_state != NMI_PULSE);
		nxt_outs.wds_n = (nxt_wd_state != WD_EXPIRED);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_state_ff <= RST_HOLD;
			rst_cnt_ff <= '0;
			nmi_state_ff <= NMI_IDLE;
			nmi_cnt_ff <= '0;
			wd_state_ff <= WD_OFF;
			wd_cnt_ff <= '0;
			strobe_prev_ff <= STROBE_RST;
			outs_ff <= OUTS_RST;
		end else begin
			rst_state_ff <= nxt_rst_state;
			rst_cnt_ff <= nxt_rst_cnt;
			nmi_state_ff <= nxt_nmi_state;
			nmi_cnt_ff <= nxt_nmi_cnt;
			wd_state_ff <= nxt_wd_state;
			wd_cnt_ff <= nxt_wd_cnt;
			strobe_prev_ff <= watchdog_strobe_n;
			outs_ff <= nxt_outs;
		end
	end

	assign reset_n = outs_ff.reset_n;
	assign reset = outs_ff.reset;
	assign nmi_n = outs_ff.nmi_n;
	assign watchdog_expired_n = outs_ff.wds_n;

	// ***************************************
	// checks
	// ***************************************
	property p_supply_reset;
		@(posedge clk) disable iff (!nrst) supply_fail_ff |=> !outs_ff.reset_n;
	endproperty
	a_supply_reset: assert property (p_supply_reset) else $error("reset not active on supply fail");
	property p_release;
		@(posedge clk) disable iff (!nrst)
		$rose(outs_ff.reset_n) |-> $past(rst_cnt_ff) == RST_HOLD_TICKS && $past(tick_ff) && !$past(supply_fail_ff);
	endproperty
	a_release: assert property (p_release) else $error("reset released before hold time");
	property p_debounce;
		@(posedge clk) disable iff (!nrst) $changed(pb_low_ff) |-> $past(pb_cnt_ff) == PB_DEBOUNCE_CYC - 1'b1;
	endproperty
	a_debounce: assert property (p_debounce) else $error("pushbutton changed without debounce");
	property p_button_reset;
		@(posedge clk) disable iff (!nrst) pb_low_ff |=> !outs_ff.reset_n ##1 !outs_ff.reset_n;
	endproperty
	a_button_reset: assert property (p_button_reset) else $error("reset not held for pushbutton");
	property p_nmi_width;
		@(posedge clk) disable iff (!nrst) $rose(outs_ff.nmi_n) |-> $past(nmi_cnt_ff) == NMI_PULSE_TICKS;
	endproperty
	a_nmi_width: assert property (p_nmi_width) else $error("interrupt pulse too short");
	property p_nmi_filter;
		@(posedge clk) disable iff (!nrst) $fell(outs_ff.nmi_n) |-> $past(sense_fail_ff) && $past(sense_low, 2);
	endproperty
	a_nmi_filter: assert property (p_nmi_filter) else $error("interrupt without filtered sense");
	property p_nmi_gate;
		@(posedge clk) disable iff (!nrst) $fell(outs_ff.nmi_n) |-> !$past(supply_low);
	endproperty
	a_nmi_gate: assert property (p_nmi_gate) else $error("interrupt while supply low");
	property p_wd_halt;
		@(posedge clk) disable iff (!nrst) !outs_ff.reset_n && outs_ff.wds_n |=> wd_cnt_ff == '0;
	endproperty
	a_wd_halt: assert property (p_wd_halt) else $error("watchdog timed during reset");
	property p_strobe;
		@(posedge clk) disable iff (!nrst)
		wd_state_ff == WD_RUN && rst_state_ff == RST_RUN && strobe_fall |=> wd_cnt_ff == '0 && outs_ff.wds_n;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe did not restart watchdog");
	property p_wds_width;
		@(posedge clk) disable iff (!nrst) $fell(outs_ff.wds_n) |=> (!outs_ff.wds_n)[*8];
	endproperty
	a_wds_width: assert property (p_wds_width) else $error("watchdog status pulse cut short");
	property p_polarity;
		@(posedge clk) disable iff (!nrst) outs_ff.reset == !outs_ff.reset_n;
	endproperty
	a_polarity: assert property (p_polarity) else $error("reset outputs not complementary");
	property p_glitch;
		@(posedge clk) disable iff (!nrst) $rose(supply_fail_ff) |-> $past(sup_cnt_ff) == SUPPLY_GLITCH_CYC - 1'b1;
	endproperty
	a_glitch: assert property (p_glitch) else $error("short supply dip accepted");
	property p_tick;
		@(posedge clk) disable iff (!nrst) tick_ff |-> $past(div_cnt_ff) == TICK_CYCLES - 1'b1 ##1 !tick_ff;
	endproperty
	a_tick: assert property (p_tick) else $error("timebase tick misplaced");
	property p_wd_restart;
		@(posedge clk) disable iff (!nrst) $rose(outs_ff.wds_n) |-> wd_cnt_ff == '0 && $past(wd_cnt_ff) == WD_EXPIRED_TICKS;
	endproperty
	a_wd_restart: assert property (p_wd_restart) else $error("watchdog did not restart after expiry");
endmodule
`default_nettype wire

// [ssw_cpu_model.sv]
// Purpose: processor model on the far side of the supervisor, striking the watchdog strobe
// Assumes: strobe line has a pull-up, so the idle level is high
// Notes: no strikes while the processor is held in reset, as a real processor would not run
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic reset_n,
	input wire logic strobe_en,
	input wire logic kick,
	output logic watchdog_strobe_n
);
	// ***************************************
	// strobe generator
	// ***************************************
	int gap;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gap = 0;
			watchdog_strobe_n <= 1'h1;
		end else if (!reset_n) begin
			// held in reset: the processor runs no code, so the strobe idles high
			gap = 0;
			watchdog_strobe_n <= 1'h1;
		end else begin
			gap = gap + 1;
			// strike far inside the timeout, with high samples between strikes
			if (kick || (strobe_en && gap >= 100)) begin
				watchdog_strobe_n <= 1'h0;
				gap = 0;
			end else if (gap == 3) begin
				watchdog_strobe_n <= 1'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [ssw_top_bench.sv]
// Purpose: self-checking bench for the supply supervisor with watchdog
// Assumes: shortened tick counts; one tick is 4 clocks, so spans are checked in clocks
// Notes: inputs change on the falling edge and outputs are sampled there, when settled
`timescale 1ns/1ps
`default_nettype none
module ssw_top_bench;
	import ssw_pkg::*;
	// ***************************************
	// signals and instances
	// ***************************************
	logic clk, nrst, supply_low, sense_low, pushbutton_reset_n, strobe_en, kick;
	logic watchdog_strobe_n, reset_n, reset, nmi_n, watchdog_expired_n;
	int fails = 0;
	int cmp_count = 0;

	ssw_top #(.TICK_CYCLES(8'h04), .RST_HOLD_TICKS(20'h00014), .NMI_PULSE_TICKS(20'h0000A),
		.WD_TIMEOUT_TICKS(20'h00032), .WD_EXPIRED_TICKS(20'h0000F)) dut_u (.clk(clk), .nrst(nrst),
		.supply_low(supply_low), .sense_low(sense_low), .pushbutton_reset_n(pushbutton_reset_n),
		.watchdog_strobe_n(watchdog_strobe_n), .reset_n(reset_n), .reset(reset), .nmi_n(nmi_n),
		.watchdog_expired_n(watchdog_expired_n));

	ssw_cpu_model cpu_u (.clk(clk), .nrst(nrst), .reset_n(reset_n), .strobe_en(strobe_en), .kick(kick),
		.watchdog_strobe_n(watchdog_strobe_n));

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	// ***************************************
	// shared tasks
	// ***************************************
	task automatic results;
		if (fails == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic seen, input logic exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return reset_n;
			1: return nmi_n;
			default: return watchdog_expired_n;
		endcase
	endfunction

	// output k must reach v no sooner than lo and before lim clocks
	task automatic span(input int k, input logic v, input int lo, input int lim, input string m);
		int n;
		n = 0;
		while (pick(k) !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		check(n >= lo && n < lim, 1'h1, m);
	endtask

	task automatic hold(input int k, input logic v, input int cyc, input string m);
		logic ok;
		ok = 1'h1;
		repeat (cyc) begin
			@(negedge clk);
			if (pick(k) !== v) ok = 1'h0;
		end
		check(ok, 1'h1, m);
	endtask

	task automatic strike;
		kick = 1'h1;
		@(negedge clk);
		kick = 1'h0;
	endtask

	always @(negedge clk) begin
		if (nrst === 1'h1) check(reset, ~reset_n, "inverted reset output");
	end

	// ***************************************
	// scenarios
	// ***************************************
	task automatic run_supply;
		supply_low = 1'h1;
		hold(0, 1'h1, 300, "short supply dip caused reset");
		supply_low = 1'h0;
		hold(0, 1'h1, 20, "reset after short dip");
		supply_low = 1'h1;
		span(0, 1'h0, 395, 420, "supply low reset timing");
		hold(0, 1'h0, 200, "reset released while supply low");
		supply_low = 1'h0;
		span(0, 1'h1, 80, 100, "supply recovery stretch");
	endtask

	task automatic run_button;
		pushbutton_reset_n = 1'h0;
		hold(0, 1'h1, 20, "button bounce caused reset");
		pushbutton_reset_n = 1'h1;
		hold(0, 1'h1, 40, "reset after button bounce");
		pushbutton_reset_n = 1'h0;
		span(0, 1'h0, 28, 40, "debounced button reset");
		hold(0, 1'h0, 150, "reset dropped while button low");
		pushbutton_reset_n = 1'h1;
		span(0, 1'h1, 108, 130, "button release stretch");
	endtask

	task automatic run_nmi;
		sense_low = 1'h1;
		hold(1, 1'h1, 900, "short sense dip raised interrupt");
		sense_low = 1'h0;
		repeat (5) @(negedge clk);
		sense_low = 1'h1;
		span(1, 1'h0, 995, 1020, "filtered interrupt timing");
		span(1, 1'h1, 40, 55, "interrupt pulse width");
		sense_low = 1'h0;
		repeat (5) @(negedge clk);
	endtask

	task automatic run_gate;
		supply_low = 1'h1;
		sense_low = 1'h1;
		hold(1, 1'h1, 1200, "interrupt while supply low");
		supply_low = 1'h0;
		span(1, 1'h0, 0, 5, "interrupt after supply recovery");
		span(0, 1'h1, 80, 100, "stretch beside interrupt");
		sense_low = 1'h0;
	endtask

	// interrupt output wired back into the button input, as a system may do
	task automatic run_loop;
		// let the earlier excursion clear so the interrupt rearms
		repeat (5) @(negedge clk);
		sense_low = 1'h1;
		repeat (1100) begin
			@(negedge clk);
			pushbutton_reset_n = nmi_n;
		end
		check(reset_n, 1'h0, "looped interrupt gave no reset");
		sense_low = 1'h0;
		span(0, 1'h1, 50, 65, "looped reset release");
	endtask

	task automatic run_watchdog;
		strobe_en = 1'h0;
		strike();
		repeat (3) begin
			hold(2, 1'h1, 150, "expiry despite strobe");
			strike();
		end
		hold(2, 1'h1, 195, "early watchdog expiry");
		span(2, 1'h0, 0, 20, "late watchdog expiry");
		span(2, 1'h1, 58, 75, "status pulse width");
		hold(2, 1'h1, 195, "early second expiry");
		span(2, 1'h0, 0, 20, "watchdog not restarted");
		span(2, 1'h1, 58, 75, "second status pulse width");
	endtask

	task automatic run_halt;
		pushbutton_reset_n = 1'h0;
		hold(2, 1'h1, 400, "watchdog timed during reset");
		pushbutton_reset_n = 1'h1;
		span(0, 1'h1, 108, 130, "release before watchdog run");
		hold(2, 1'h1, 195, "watchdog started before reset end");
		span(2, 1'h0, 0, 20, "watchdog not started at reset end");
	endtask

	// ***************************************
	// main sequence and watchdog of the run
	// ***************************************
	initial begin
		nrst = 1'h0;
		supply_low = 1'h0;
		sense_low = 1'h0;
		pushbutton_reset_n = 1'h1;
		strobe_en = 1'h1;
		kick = 1'h0;
		repeat (5) @(negedge clk);
		check(reset_n, 1'h0, "reset output during reset");
		check(nmi_n, 1'h1, "interrupt during reset");
		check(watchdog_expired_n, 1'h1, "status during reset");
		nrst = 1'h1;
		span(0, 1'h1, 78, 100, "power-up stretch");
		run_supply();
		run_button();
		run_nmi();
		run_gate();
		run_loop();
		run_watchdog();
		run_halt();
		results();
	end

	initial begin
		// the sequence needs about 8000 clocks; a generous margin before calling it hung
		repeat (20000) @(posedge clk);
		fails++;
		results();
	end
endmodule
`default_nettype wire
